// File: src/vlsb_consts.vh
`ifndef VLSB_CONSTS_VH
`define VLSB_CONSTS_VH

// Register byte offsets
`define VLSB_ADR_LI_STATUS 8'h00
`define VLSB_ADR_LI_MODE 8'h04
`define VLSB_ADR_LI_SET 8'h08
`define VLSB_ADR_LI_CLEAR 8'h0c
`define VLSB_ADR_LO_STATUS 8'h10
`define VLSB_ADR_LI_PULSE 8'h14
`define VLSB_ADR_LABEL_SEL 8'h18
`define VLSB_ADR_LABEL_DATA 8'h1c

// Label select fields
`define VLSB_LSEL_WORD_LSB 0
`define VLSB_LSEL_LABEL_LSB 3
`define VLSB_LSEL_OUT_BIT 8
`define VLSB_LSEL_WIDTH 9

// Reset values
`define VLSB_RST_LI_STATUS 32'h0000_0000
`define VLSB_RST_LI_MODE 32'h0000_0000
`define VLSB_RST_LABEL_SEL 9'h000

// Timing
`define VLSB_CLK_KHZ 25000
`define VLSB_PULSE_US 5000
`define VLSB_PULSE_CYCLES ((`VLSB_PULSE_US * `VLSB_CLK_KHZ + 999) / 1000)
`define VLSB_PULSE_CNT_W 17

`endif

// File: src/vlsb_pulse_timer.v
`timescale 1ns/100ps
`default_nettype none

module vlsb_pulse_timer #(
   parameter CNT_W = 17,
   parameter [CNT_W-1:0] PULSE_CYCLES = 17'd125000
) (
   input wire core_clk,
   input wire rst_n,
   input wire start,
   input wire stop,
   output wire busy,
   output wire expire
);
   reg [CNT_W-1:0] cnt;

   // Counts down from the pulse length; expire marks the last high cycle
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= {CNT_W{1'b0}};
      end else if (stop) begin
         cnt <= {CNT_W{1'b0}};
      end else if (start) begin
         cnt <= PULSE_CYCLES;
      end else if (cnt != {CNT_W{1'b0}}) begin
         cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign busy = (cnt != {CNT_W{1'b0}});
   assign expire = (cnt == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule

`default_nettype wire

// File: src/vlsb_bank.v
`timescale 1ns/100ps
`default_nettype none
`include "vlsb_consts.vh"

module vlsb_bank #(
   parameter PULSE_CYCLES = `VLSB_PULSE_CYCLES
) (
   input wire core_clk,
   input wire rst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire mimic_cmd_valid,
   input wire [4:0] mimic_cmd_index,
   input wire mimic_cmd_value,
   input wire [31:0] user_logic_out,
   output reg [31:0] logic_in_status,
   output reg [31:0] logic_out_status
);
   localparam N = 32;
   localparam CW = `VLSB_PULSE_CNT_W;
   localparam [CW-1:0] PULSE_LEN = PULSE_CYCLES[CW-1:0];
   localparam NWORDS = 512;

   // Expands byte enables to a bit mask
   function [31:0] byte_mask;
      input [3:0] sel;
      begin
         byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      end
   endfunction

   // One-hot decode of an input index
   function [31:0] one_hot;
      input [4:0] idx;
      begin
         one_hot = 32'h0000_0001 << idx;
      end
   endfunction

   // Match of the bus address against one register offset
   function adr_hit;
      input [7:0] adr;
      input [7:0] loc;
      begin
         adr_hit = (adr == loc);
      end
   endfunction

   // One character of a default label: "Logical input n" / "output n"
   function [7:0] label_byte;
      input is_out;
      input [4:0] idx;
      input [4:0] pos;
      reg [119:0] pfx;
      reg [5:0] num;
      reg [5:0] tens;
      reg [5:0] ones;
      reg [5:0] plen;
      reg [5:0] p;
      begin
         num = {1'b0, idx} + 6'h01;
         tens = num / 6'd10;
         ones = num % 6'd10;
         p = {1'b0, pos};
         if (is_out) begin
            pfx = "Logical output ";
            plen = 6'd15;
         end else begin
            pfx = {"Logical input ", 8'h00};
            plen = 6'd14;
         end
         if (p < plen) begin
            label_byte = pfx[(119 - 8 * p) -: 8];
         end else if (p == plen) begin
            if (tens != 6'h00) begin
               label_byte = 8'h30 + {2'b00, tens};
            end else begin
               label_byte = 8'h30 + {2'b00, ones};
            end
         end else if ((p == plen + 6'h01) && (tens != 6'h00)) begin
            label_byte = 8'h30 + {2'b00, ones};
         end else begin
            label_byte = 8'h00;
         end
      end
   endfunction

   // Four default characters of one label word, first in the low byte
   function [31:0] label_word;
      input [`VLSB_LSEL_WIDTH-1:0] sel;
      reg is_out;
      reg [4:0] idx;
      reg [4:0] base;
      begin
         is_out = sel[`VLSB_LSEL_OUT_BIT];
         idx = sel[`VLSB_LSEL_LABEL_LSB +: 5];
         base = {sel[`VLSB_LSEL_WORD_LSB +: 3], 2'b00};
         label_word = {label_byte(is_out, idx, base + 5'd3),
                       label_byte(is_out, idx, base + 5'd2),
                       label_byte(is_out, idx, base + 5'd1),
                       label_byte(is_out, idx, base)};
      end
   endfunction

   reg [31:0] li_mode;
   reg [`VLSB_LSEL_WIDTH-1:0] label_sel;
   reg [31:0] label_mem [0:NWORDS-1];
   reg [NWORDS-1:0] label_edit;
   reg [31:0] next_status;
   reg [31:0] next_dat;

   wire bus_req = wb_cyc_i & wb_stb_i;
   wire bus_take = bus_req & ~wb_ack_o;
   wire bus_wr = bus_req & wb_ack_o & wb_we_i;
   // Write strobes, one per writable register
   wire wr_mode = bus_wr & adr_hit(wb_adr_i, `VLSB_ADR_LI_MODE);
   wire wr_set = bus_wr & adr_hit(wb_adr_i, `VLSB_ADR_LI_SET);
   wire wr_clr = bus_wr & adr_hit(wb_adr_i, `VLSB_ADR_LI_CLEAR);
   wire wr_lsel = bus_wr & adr_hit(wb_adr_i, `VLSB_ADR_LABEL_SEL);
   wire wr_ldata = bus_wr & adr_hit(wb_adr_i, `VLSB_ADR_LABEL_DATA);

   wire [31:0] wmask = byte_mask(wb_sel_i);
   wire [31:0] mimic_hot = one_hot(mimic_cmd_index);
   wire [31:0] bus_set;
   wire [31:0] bus_clr;
   wire [31:0] set_cmd;
   wire [31:0] clr_cmd;
   wire [31:0] pulse_busy;
   wire [31:0] pulse_expire;
   wire [31:0] pulse_run = pulse_busy & li_mode;
   // Stored text once a word is written, default text before that
   wire label_written = label_edit[label_sel];
   wire [31:0] label_cur = label_written ? label_mem[label_sel] :
                           label_word(label_sel);

   // Bus writes to the command registers and mimic switch commands
   assign bus_set = wr_set ? (wb_dat_i & wmask) :
                    32'h0000_0000;
   assign bus_clr = wr_clr ? (wb_dat_i & wmask) :
                    32'h0000_0000;
   assign set_cmd = bus_set | ((mimic_cmd_valid && mimic_cmd_value) ?
                    mimic_hot : 32'h0000_0000);
   assign clr_cmd = bus_clr | ((mimic_cmd_valid && !mimic_cmd_value) ?
                    mimic_hot : 32'h0000_0000);

   // One pulse timer per logical input
   genvar gi;
   generate
      for (gi = 0; gi < N; gi = gi + 1) begin : g_pulse
         // A 1 command in pulse mode restarts the timer; hold mode parks it
         wire start_cmd = set_cmd[gi] & li_mode[gi];
         wire stop_cmd = clr_cmd[gi] | ~li_mode[gi];
         vlsb_pulse_timer #(
            .CNT_W(CW),
            .PULSE_CYCLES(PULSE_LEN)
         ) u_timer (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .start(start_cmd),
            .stop(stop_cmd),
            .busy(pulse_busy[gi]),
            .expire(pulse_expire[gi])
         );
      end
   endgenerate

   // Next status: a 0 command wins, then a 1 command, then pulse expiry
   integer i;
   always @* begin
      next_status = logic_in_status;
      for (i = 0; i < N; i = i + 1) begin
         if (clr_cmd[i]) begin
            next_status[i] = 1'b0;
         end else if (set_cmd[i]) begin
            next_status[i] = 1'b1;
         end else if (li_mode[i] && pulse_expire[i]) begin
            next_status[i] = 1'b0;
         end
      end
   end

   // Logical input status, cleared on every reset
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         logic_in_status <= `VLSB_RST_LI_STATUS;
      end else begin
         logic_in_status <= next_status;
      end
   end

   // Logical outputs carried from user logic
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         logic_out_status <= 32'h0000_0000;
      end else begin
         logic_out_status <= user_logic_out;
      end
   end

   // Mode and label select registers
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         li_mode <= `VLSB_RST_LI_MODE;
         label_sel <= `VLSB_RST_LABEL_SEL;
      end else begin
         // Mode bit 1 is pulse, 0 is hold
         if (wr_mode) begin
            li_mode <= (li_mode & ~wmask) | (wb_dat_i & wmask);
         end
         // Select: word and index in the low byte, output flag above
         if (wr_lsel) begin
            if (wb_sel_i[0]) begin
               label_sel[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               label_sel[8] <= wb_dat_i[8];
            end
         end
      end
   end

   // Label text storage; an unwritten word reads its default text
   always @(posedge core_clk) begin
      if (wr_ldata) begin
         label_mem[label_sel] <= (label_cur & ~wmask) |
                                 (wb_dat_i & wmask);
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         label_edit <= {NWORDS{1'b0}};
      end else if (wr_ldata) begin
         label_edit[label_sel] <= 1'b1;
      end
   end

   // Read data selection; unmapped addresses read as zero
   always @* begin
      case (wb_adr_i)
         `VLSB_ADR_LI_STATUS: begin
            next_dat = logic_in_status;
         end
         `VLSB_ADR_LI_MODE: begin
            next_dat = li_mode;
         end
         // Command registers are write-only and read as zero
         `VLSB_ADR_LI_SET: begin
            next_dat = 32'h0000_0000;
         end
         `VLSB_ADR_LI_CLEAR: begin
            next_dat = 32'h0000_0000;
         end
         `VLSB_ADR_LO_STATUS: begin
            next_dat = logic_out_status;
         end
         `VLSB_ADR_LI_PULSE: begin
            next_dat = pulse_run;
         end
         `VLSB_ADR_LABEL_SEL: begin
            next_dat = {23'h000000, label_sel};
         end
         `VLSB_ADR_LABEL_DATA: begin
            next_dat = label_cur;
         end
         default: begin
            next_dat = 32'h0000_0000;
         end
      endcase
   end

   // Wishbone classic slave: ack one cycle after the request, one cycle
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_take;
         // Read data is captured as the request is taken
         if (bus_take) begin
            wb_dat_o <= next_dat;
         end
      end
   end
endmodule

`default_nettype wire

// File: tb/vlsb_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "vlsb_consts.vh"
module vlsb_sva (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic mimic_cmd_valid,
   input wire logic [4:0] mimic_cmd_index,
   input wire logic mimic_cmd_value,
   input wire logic [31:0] user_logic_out,
   input wire logic [31:0] logic_in_status,
   input wire logic [31:0] logic_out_status
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   AST_RST: assert property (disable iff (1'b0) !rst_n |-> !logic_in_status)
      else $error("status kept in reset");
   AST_SET: assert property (mimic_cmd_valid && mimic_cmd_value && !wb_cyc_i
      |=> logic_in_status[$past(mimic_cmd_index)]) else $error("set lost");
   AST_CLR: assert property (mimic_cmd_valid && !mimic_cmd_value
      |=> !logic_in_status[$past(mimic_cmd_index)]) else $error("clear lost");
   AST_NO_RISE: assert property (!mimic_cmd_valid && !(wb_ack_o && wb_we_i)
      |=> !(logic_in_status & ~$past(logic_in_status))) else $error("rise");
   AST_LO: assert property ($past(rst_n)
      |-> logic_out_status == $past(user_logic_out)) else $error("lo lag");
   AST_RD: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i == `VLSB_ADR_LO_STATUS |-> wb_dat_o == $past(logic_out_status))
      else $error("lo read");
   cover property (mimic_cmd_valid && mimic_cmd_value);
   cover property ($fell(logic_in_status[5]));
   cover property (wb_ack_o && wb_we_i);
endmodule
bind vlsb_bank vlsb_sva chk (.core_clk(core_clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .mimic_cmd_valid(mimic_cmd_valid), .mimic_cmd_index(mimic_cmd_index),
   .mimic_cmd_value(mimic_cmd_value), .user_logic_out(user_logic_out),
   .logic_in_status(logic_in_status), .logic_out_status(logic_out_status));
`default_nettype wire

// File: tb/vlsb_mimic.sv
`timescale 1ns/100ps
`default_nettype none
module vlsb_mimic (
   input wire logic core_clk,
   output logic valid = 1'b0,
   output logic [4:0] idx = 5'h0,
   output logic val = 1'b0
);
   // One switch press, a one-cycle strobe
   task press(input [4:0] i, input v);
      @(posedge core_clk);
      valid <= 1'b1;
      idx <= i;
      val <= v;
      @(posedge core_clk);
      valid <= 1'b0;
      idx <= ~i;
      val <= ~v;
   endtask
endmodule
`default_nettype wire

// File: tb/virtual_logic_signal_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module virtual_logic_signal_bank_tb;
   logic core_clk = 0, rst_n = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 0;
   logic [3:0] sel = 4'hf, bsel = 4'hf;
   logic [31:0] dat = 0, ulo = 0, r;
   wire logic [31:0] dat_o, lis, los;
   wire logic ack, mv, mval;
   wire logic [4:0] mi;
   int failures = 0, check_count = 0, n;
   logic [31:0] q[$];
   vlsb_bank #(.PULSE_CYCLES(8)) uut (.core_clk(core_clk), .rst_n(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .mimic_cmd_valid(mv), .mimic_cmd_index(mi), .mimic_cmd_value(mval),
      .user_logic_out(ulo), .logic_in_status(lis), .logic_out_status(los));
   vlsb_mimic m (.core_clk(core_clk), .valid(mv), .idx(mi), .val(mval));
   initial forever #20 core_clk = ~core_clk;
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input [31:0] s, input [31:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask
   task give_verdict;
      if (failures == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wb(input [7:0] a, input w, input [31:0] d);
      @(posedge core_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= bsel;
      do @(posedge core_clk); while (ack !== 1'b1);
      cyc <= 0;
      stb <= 0;
   endtask
   task rd(input [7:0] a, input [31:0] e);
      q.push_back(e);
      wb(a, 0, 32'h0);
   endtask
   always @(posedge core_clk)
      if (ack === 1'b1 && !we) chk(dat_o, q.pop_front());
   initial begin
      #400000;
      failures++;
      give_verdict;
   end
   initial begin
      rst_n <= 0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1;
      r = lfsr(32'd31);
      rd(8'h00, 32'h0);
      wb(8'h08, 1, r);
      wb(8'h08, 1, r);
      rd(8'h00, r);
      wb(8'h0c, 1, 32'h0000ffff);
      rd(8'h00, r & 32'hffff0000);
      wb(8'h0c, 1, 32'hffffffff);
      m.press(5'd3, 1);
      repeat (20) @(posedge core_clk);
      chk(lis, 32'h8);
      m.press(5'd3, 0);
      @(posedge core_clk);
      chk(lis, 32'h0);
      wb(8'h04, 1, 32'h20);
      rd(8'h04, 32'h20);
      m.press(5'd5, 1);
      n = 0;
      repeat (20) begin
         @(posedge core_clk);
         if (lis[5] === 1'b1) n++;
      end
      chk(32'(n), 32'd8);
      m.press(5'd5, 1);
      rd(8'h14, 32'h20);
      r = lfsr(r);
      ulo <= r;
      rd(8'h10, r);
      chk(los, r);
      wb(8'h18, 1, 32'h10b);
      rd(8'h1c, 32'h32207475);
      r = lfsr(r);
      wb(8'h1c, 1, r);
      rd(8'h1c, r);
      rd(8'h18, 32'h10b);
      wb(8'h18, 1, 32'h10a);
      bsel = 4'h1;
      wb(8'h1c, 1, r);
      bsel = 4'hf;
      rd(8'h1c, {24'h707475, r[7:0]});
      rd(8'h20, 32'h0);
      m.press(5'd9, 1);
      rst_n <= 0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1;
      rd(8'h00, 32'h0);
      rd(8'h1c, 32'h69676f4c);
      repeat (3) @(posedge core_clk);
      give_verdict;
   end
endmodule
`default_nettype wire
